// File: design/lbdc_pkg.sv
// Purpose: constants and types of the latched dual bank cache SRAM controller
// Assumes: 20 MHz clk_sys; SRAM pins treated as synchronous outputs and inputs
package lbdc_pkg;
  localparam int CLK_NS = 50;
  localparam int T_STROBE_NS = 10;
  localparam int T_ADDR_HOLD_NS = 5;
  localparam int T_ACCESS_NS = 35;
  localparam int T_WRITE_PULSE_NS = 25;
  localparam int T_TURN_NS = 25;
  localparam logic [3:0] STROBE_CYC = 4'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] HOLD_CYC = 4'((T_ADDR_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] ACCESS_CYC = 4'((T_ACCESS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] WPULSE_CYC = 4'((T_WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] TURN_CYC = 4'((T_TURN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_RDATA = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam int CTRL_DUAL_BIT = 0;
  localparam int CTRL_CE_END_BIT = 1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_WRITE_BIT = 16;
  localparam int CMD_BANK_A_BIT = 17;
  localparam int CMD_BANK_B_BIT = 18;
  localparam int CMD_LOW_BYTE_BIT = 19;
  localparam int CMD_UP_BYTE_BIT = 20;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_REFUSED_BIT = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE, ST_LATCH, ST_HOLD, ST_READ, ST_WPULSE, ST_WEND, ST_RECOVER
  } lbdc_state_t;
endpackage : lbdc_pkg

// File: design/lbdc_timer.sv
// Purpose: phase timer for pin sequencing
// Assumes: load is a one-cycle pulse, count at least one
// Notes: expired is a one-cycle pulse count edges after the load is taken
`timescale 1ns/1ps
`default_nettype none
module lbdc_timer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // control
  input wire logic load,
  input wire logic [3:0] count,
  // status
  output logic expired
);
  logic [3:0] cnt_q;
  logic expired_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 4'h0;
      expired_q <= 1'b0;
    end else if (load) begin
      cnt_q <= count;
      expired_q <= 1'b0;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
      expired_q <= (cnt_q == 4'h1);
    end else begin
      expired_q <= 1'b0;
    end
  end

  assign expired = expired_q;
endmodule : lbdc_timer
`default_nettype wire

// File: design/lbdc_ctrl.sv
// Purpose: AXI4-Lite driven controller for the latched dual bank cache SRAM
// Assumes: SRAM pins sampled and driven on clk_sys; one access at a time
// Notes: a command written while busy is refused and flagged in status
`timescale 1ns/1ps
`default_nettype none
module lbdc_ctrl
  import lbdc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // axi4-lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // sram address and configuration
  output logic address_latch_strobe,
  output logic [11:0] low_address_bits,
  output logic top_address_bit,
  output logic mode_select,
  // sram enables
  output logic chip_enable_n,
  output logic lower_byte_select_n,
  output logic upper_byte_select_n,
  output logic bank_a_output_enable_n,
  output logic bank_b_output_enable_n,
  output logic bank_a_write_enable_n,
  output logic bank_b_write_enable_n,
  // sram data lines
  input wire logic [7:0] lower_byte_lines_i,
  output logic [7:0] lower_byte_lines_o,
  output logic lower_byte_lines_oe,
  input wire logic [7:0] upper_byte_lines_i,
  output logic [7:0] upper_byte_lines_o,
  output logic upper_byte_lines_oe
);
  lbdc_state_t st_q;
  logic [31:0] ctrl_q, cmd_q, wdata_q;
  logic [15:0] rdata_q;
  logic done_q, refused_q;
  logic aw_rdy_q, w_rdy_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] awaddr_q;
  logic [31:0] wbuf_q, rd_d, rdata_bus_q;
  logic wr_fire, start, tmr_load_q, tmr_exp;
  logic [3:0] tmr_cnt_q, strb_q;
  logic strobe_q, top_q, ce_n_q, ls_n_q, us_n_q, oea_n_q, oeb_n_q, wea_n_q, web_n_q;
  logic [11:0] addr_q;
  logic [7:0] lo_o_q, up_o_q;
  logic lo_oe_q, up_oe_q;

  // write path: address and data taken in either order, response after both
  assign wr_fire = !aw_rdy_q && !w_rdy_q && !bvalid_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      aw_rdy_q <= 1'b1;
      w_rdy_q <= 1'b1;
      awaddr_q <= 8'h00;
      wbuf_q <= 32'h0000_0000;
      strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && aw_rdy_q) begin
        aw_rdy_q <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && w_rdy_q) begin
        w_rdy_q <= 1'b0;
        wbuf_q <= s_axi_wdata;
        strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= (awaddr_q == OFS_CTRL || awaddr_q == OFS_CMD ||
                    awaddr_q == OFS_WDATA) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        aw_rdy_q <= 1'b1;
        w_rdy_q <= 1'b1;
      end
    end
  end

  // byte lane mask from the strobes taken with the data
  logic [31:0] lane_mask;
  assign lane_mask = {{8{strb_q[3]}}, {8{strb_q[2]}}, {8{strb_q[1]}}, {8{strb_q[0]}}};

  // software registers
  assign start = wr_fire && (awaddr_q == OFS_CMD) && (st_q == ST_IDLE);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RST;
      cmd_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
    end else if (wr_fire) begin
      if (awaddr_q == OFS_CTRL && st_q == ST_IDLE) begin
        ctrl_q <= (ctrl_q & ~lane_mask) | (wbuf_q & lane_mask);
      end
      if (start) begin
        cmd_q <= (cmd_q & ~lane_mask) | (wbuf_q & lane_mask);
      end
      if (awaddr_q == OFS_WDATA) begin
        wdata_q <= (wdata_q & ~lane_mask) | (wbuf_q & lane_mask);
      end
    end
  end

  // status flags: a completion in the clearing cycle still sets done
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      done_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      done_q <= (st_q == ST_RECOVER && tmr_exp) || (done_q && !start);
      refused_q <= (wr_fire && awaddr_q == OFS_CMD && st_q != ST_IDLE) ||
                   (refused_q && !start);
    end
  end

  // read path
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (s_axi_araddr)
      OFS_CTRL: rd_d = ctrl_q;
      OFS_CMD: rd_d = cmd_q;
      OFS_WDATA: rd_d = wdata_q;
      OFS_RDATA: rd_d = {16'h0000, rdata_q};
      OFS_STATUS: begin
        rd_d[STAT_BUSY_BIT] = (st_q != ST_IDLE);
        rd_d[STAT_DONE_BIT] = done_q;
        rd_d[STAT_REFUSED_BIT] = refused_q;
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_bus_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_bus_q <= rd_d;
      rresp_q <= (s_axi_araddr <= OFS_STATUS && s_axi_araddr[1:0] == 2'h0) ?
                 RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end
  lbdc_timer u_timer (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .load(tmr_load_q),
    .count(tmr_cnt_q),
    .expired(tmr_exp)
  );

  // pin sequencer
  logic dual, op_wr, op_a, op_b;
  assign dual = ctrl_q[CTRL_DUAL_BIT];
  assign op_wr = cmd_q[CMD_WRITE_BIT];
  assign op_a = cmd_q[CMD_BANK_A_BIT];
  assign op_b = cmd_q[CMD_BANK_B_BIT];
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_IDLE;
      tmr_load_q <= 1'b0;
      tmr_cnt_q <= 4'h0;
      strobe_q <= 1'b0;
      addr_q <= 12'h000;
      top_q <= 1'b0;
      ce_n_q <= 1'b1;
      ls_n_q <= 1'b1;
      us_n_q <= 1'b1;
      oea_n_q <= 1'b1;
      oeb_n_q <= 1'b1;
      wea_n_q <= 1'b1;
      web_n_q <= 1'b1;
      lo_o_q <= 8'h00;
      up_o_q <= 8'h00;
      lo_oe_q <= 1'b0;
      up_oe_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      tmr_load_q <= 1'b0;
      unique case (st_q)
        ST_IDLE: if (start) begin
          // address presented with the strobe high, latch transparent
          addr_q <= wbuf_q[CMD_ADDR_LSB +: 12];
          top_q <= wbuf_q[CMD_ADDR_LSB + 12];
          strobe_q <= 1'b1;
          tmr_cnt_q <= STROBE_CYC;
          tmr_load_q <= 1'b1;
          st_q <= ST_LATCH;
        end
        ST_LATCH: if (tmr_exp) begin
          strobe_q <= 1'b0; // falling edge captures the address
          tmr_cnt_q <= HOLD_CYC;
          tmr_load_q <= 1'b1;
          st_q <= ST_HOLD;
        end
        ST_HOLD: if (tmr_exp) begin
          ce_n_q <= 1'b0;
          ls_n_q <= !cmd_q[CMD_LOW_BYTE_BIT];
          us_n_q <= !cmd_q[CMD_UP_BYTE_BIT];
          tmr_load_q <= 1'b1;
          if (op_wr) begin
            lo_o_q <= wdata_q[7:0];
            up_o_q <= wdata_q[15:8];
            lo_oe_q <= cmd_q[CMD_LOW_BYTE_BIT];
            up_oe_q <= cmd_q[CMD_UP_BYTE_BIT];
            // single mode drives both write enables together
            wea_n_q <= dual ? !op_a : 1'b0;
            web_n_q <= dual ? !op_b : 1'b0;
            tmr_cnt_q <= WPULSE_CYC;
            st_q <= ST_WPULSE;
          end else begin
            // dual mode reads one bank only, single mode both enables
            oea_n_q <= dual ? !op_a : 1'b0;
            oeb_n_q <= dual ? op_a : 1'b0;
            tmr_cnt_q <= ACCESS_CYC;
            st_q <= ST_READ;
          end
        end
        ST_READ: if (tmr_exp) begin
          rdata_q <= {us_n_q ? 8'h00 : upper_byte_lines_i,
                      ls_n_q ? 8'h00 : lower_byte_lines_i};
          oea_n_q <= 1'b1;
          oeb_n_q <= 1'b1;
          ce_n_q <= 1'b1;
          ls_n_q <= 1'b1;
          us_n_q <= 1'b1;
          tmr_cnt_q <= TURN_CYC;
          tmr_load_q <= 1'b1;
          st_q <= ST_RECOVER;
        end
        ST_WPULSE: if (tmr_exp) begin
          if (ctrl_q[CTRL_CE_END_BIT]) begin
            ce_n_q <= 1'b1; // chip enable ends the write, write enables held
          end else begin
            wea_n_q <= 1'b1;
            web_n_q <= 1'b1;
          end
          tmr_cnt_q <= HOLD_CYC;
          tmr_load_q <= 1'b1;
          st_q <= ST_WEND;
        end
        ST_WEND: if (tmr_exp) begin
          wea_n_q <= 1'b1;
          web_n_q <= 1'b1;
          ce_n_q <= 1'b1;
          ls_n_q <= 1'b1;
          us_n_q <= 1'b1;
          lo_oe_q <= 1'b0;
          up_oe_q <= 1'b0;
          tmr_cnt_q <= TURN_CYC;
          tmr_load_q <= 1'b1;
          st_q <= ST_RECOVER;
        end
        ST_RECOVER: if (tmr_exp) begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign s_axi_awready = aw_rdy_q;
  assign s_axi_wready = w_rdy_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_bus_q;
  assign s_axi_rresp = rresp_q;
  assign address_latch_strobe = strobe_q;
  assign low_address_bits = addr_q;
  assign top_address_bit = top_q;
  assign mode_select = dual;
  assign chip_enable_n = ce_n_q;
  assign lower_byte_select_n = ls_n_q;
  assign upper_byte_select_n = us_n_q;
  assign bank_a_output_enable_n = oea_n_q;
  assign bank_b_output_enable_n = oeb_n_q;
  assign bank_a_write_enable_n = wea_n_q;
  assign bank_b_write_enable_n = web_n_q;
  assign lower_byte_lines_o = lo_o_q;
  assign lower_byte_lines_oe = lo_oe_q;
  assign upper_byte_lines_o = up_o_q;
  assign upper_byte_lines_oe = up_oe_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_latch_phase;
    strobe_q ##[1:6] !strobe_q;
  endsequence
  sequence s_enable_phase;
    ##[1:6] !ce_n_q;
  endsequence
  a_latch_then_enable: assert property ($rose(strobe_q) |-> s_latch_phase ##0 s_enable_phase)
    else $error("chip enable did not follow the address latch");
  a_addr_hold_fall: assert property ($fell(strobe_q) |=> $stable(addr_q) && $stable(top_q))
    else $error("address changed right after the latch strobe fell");
  a_read_no_write: assert property ((!oea_n_q || !oeb_n_q) |-> wea_n_q && web_n_q)
    else $error("write enable low during a read");
  a_read_selects: assert property ((!oea_n_q || !oeb_n_q) |-> !ce_n_q && !(ls_n_q && us_n_q))
    else $error("read without chip enable or byte select");
  a_single_oe_joined: assert property (!dual |-> oea_n_q == oeb_n_q)
    else $error("output enables split in single mode");
  a_single_we_joined: assert property (!dual && !ce_n_q |-> wea_n_q == web_n_q)
    else $error("write enables split in single mode");
  a_ce_end_write: assert property (st_q == ST_WPULSE && tmr_exp && ctrl_q[CTRL_CE_END_BIT]
      |=> ce_n_q && !(wea_n_q && web_n_q) ##[1:3] wea_n_q && web_n_q)
    else $error("chip enable controlled write ended wrongly");
  a_no_drive_read: assert property ((lo_oe_q || up_oe_q) |-> oea_n_q && oeb_n_q)
    else $error("controller drives data while reading");
  a_bvalid_hold: assert property (bvalid_q && !s_axi_bready |=> bvalid_q)
    else $error("write response dropped before it was taken");
endmodule : lbdc_ctrl
`default_nettype wire

// File: tb/lbdc_sram_model.sv
// Purpose: behavioural model of the latched dual bank cache data sram
// Assumes: clockless device; levels decide reads and writes
// Notes: released data lines show the inverse of their last driven value
`timescale 1ns/1ps
`default_nettype none
module lbdc_sram_model #(
  parameter int ACC_NS = 35
) (
  // configuration and address
  input wire logic mode_select,
  input wire logic address_latch_strobe,
  input wire logic [11:0] low_address_bits,
  input wire logic top_address_bit,
  // enables
  input wire logic chip_enable_n,
  input wire logic lower_byte_select_n,
  input wire logic upper_byte_select_n,
  input wire logic bank_a_output_enable_n,
  input wire logic bank_b_output_enable_n,
  input wire logic bank_a_write_enable_n,
  input wire logic bank_b_write_enable_n,
  // data lines
  input wire logic [7:0] lower_byte_lines_o,
  input wire logic lower_byte_lines_oe,
  input wire logic [7:0] upper_byte_lines_o,
  input wire logic upper_byte_lines_oe,
  output logic [7:0] lower_byte_lines_i,
  output logic [7:0] upper_byte_lines_i
);
  // contents start unknown, latch has no reset
  logic [15:0] bank_a [0:4095];
  logic [15:0] bank_b [0:4095];
  logic [12:0] addr_q;
  logic [15:0] rd_d, last_q, bus;
  logic live, sel_a, sel_b, rd_on, rd_dly, rd_now, wr_on, wr_a, wr_b, dev_lo, dev_up;
  // transparent while strobe high, held from its fall
  always_latch begin
    if (address_latch_strobe) addr_q <= {top_address_bit, low_address_bits};
  end
  // chip enable and at least one byte select gate reads and writes; the address latch follows the strobe alone
  assign live = !chip_enable_n && !(lower_byte_select_n && upper_byte_select_n);
  // dual: exactly one enable picks a bank; single: both low, top bit picks
  assign sel_a = mode_select ? (!bank_a_output_enable_n && bank_b_output_enable_n)
                             : (!bank_a_output_enable_n && !bank_b_output_enable_n && !addr_q[12]);
  assign sel_b = mode_select ? (bank_a_output_enable_n && !bank_b_output_enable_n)
                             : (!bank_a_output_enable_n && !bank_b_output_enable_n && addr_q[12]);
  // no drive during a write; data appear after the access time
  assign rd_on = live && bank_a_write_enable_n && bank_b_write_enable_n && (sel_a || sel_b);
  assign #(ACC_NS) rd_dly = rd_on;
  assign rd_now = rd_on && rd_dly;
  assign rd_d = sel_a ? bank_a[addr_q[11:0]] : bank_b[addr_q[11:0]];
  // dual writes per bank enable, single needs both; raising chip enable ends it
  assign wr_on = live && (mode_select ? (!bank_a_write_enable_n || !bank_b_write_enable_n)
                                      : (!bank_a_write_enable_n && !bank_b_write_enable_n));
  assign wr_a = wr_on && (mode_select ? !bank_a_write_enable_n : !addr_q[12]);
  assign wr_b = wr_on && (mode_select ? !bank_b_write_enable_n : addr_q[12]);
  // byte selects pick the lanes for reads and writes
  assign dev_lo = rd_now && !lower_byte_select_n;
  assign dev_up = rd_now && !upper_byte_select_n;
  always @* begin
    if (wr_a && !lower_byte_select_n) bank_a[addr_q[11:0]][7:0] = bus[7:0];
    if (wr_a && !upper_byte_select_n) bank_a[addr_q[11:0]][15:8] = bus[15:8];
    if (wr_b && !lower_byte_select_n) bank_b[addr_q[11:0]][7:0] = bus[7:0];
    if (wr_b && !upper_byte_select_n) bank_b[addr_q[11:0]][15:8] = bus[15:8];
  end
  always @* begin
    if (lower_byte_lines_oe) last_q[7:0] = lower_byte_lines_o;
    else if (dev_lo) last_q[7:0] = rd_d[7:0];
    if (upper_byte_lines_oe) last_q[15:8] = upper_byte_lines_o;
    else if (dev_up) last_q[15:8] = rd_d[15:8];
  end
  assign bus[7:0] = lower_byte_lines_oe ? lower_byte_lines_o : dev_lo ? rd_d[7:0] : ~last_q[7:0];
  assign bus[15:8] = upper_byte_lines_oe ? upper_byte_lines_o : dev_up ? rd_d[15:8] : ~last_q[15:8];
  assign lower_byte_lines_i = bus[7:0];
  assign upper_byte_lines_i = bus[15:8];
endmodule : lbdc_sram_model
`default_nettype wire

// File: tb/lbdc_ctrl_test.sv
// Purpose: self-checking bench for the cache sram controller
// Assumes: device model on the far side; axi4-lite master tasks
// Notes: expected data follow from the memory behaviour alone
`timescale 1ns/1ps
`default_nettype none
module lbdc_ctrl_test
  import lbdc_pkg::*;
;
  localparam logic [4:0] F_W = 5'h01, F_A = 5'h02, F_B = 5'h04, F_LO = 5'h08, F_UP = 5'h10;
  localparam logic [4:0] F_AB = 5'h1E;
  logic clk_sys, rst_b;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic address_latch_strobe, top_address_bit, mode_select, chip_enable_n;
  logic lower_byte_select_n, upper_byte_select_n, lower_byte_lines_oe, upper_byte_lines_oe;
  logic bank_a_output_enable_n, bank_b_output_enable_n;
  logic bank_a_write_enable_n, bank_b_write_enable_n;
  logic [11:0] low_address_bits;
  logic [7:0] lower_byte_lines_i, lower_byte_lines_o, upper_byte_lines_i, upper_byte_lines_o;
  int error_cnt, checks_done;
  lbdc_ctrl lbdc_ctrl_i (.clk_sys, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .address_latch_strobe, .low_address_bits, .top_address_bit,
    .mode_select, .chip_enable_n, .lower_byte_select_n, .upper_byte_select_n,
    .bank_a_output_enable_n, .bank_b_output_enable_n, .bank_a_write_enable_n,
    .bank_b_write_enable_n, .lower_byte_lines_i, .lower_byte_lines_o, .lower_byte_lines_oe,
    .upper_byte_lines_i, .upper_byte_lines_o, .upper_byte_lines_oe);
  lbdc_sram_model #(.ACC_NS(T_ACCESS_NS)) lbdc_sram_model_i (.mode_select,
    .address_latch_strobe, .low_address_bits, .top_address_bit, .chip_enable_n,
    .lower_byte_select_n, .upper_byte_select_n, .bank_a_output_enable_n,
    .bank_b_output_enable_n, .bank_a_write_enable_n, .bank_b_write_enable_n,
    .lower_byte_lines_o, .lower_byte_lines_oe, .upper_byte_lines_o, .upper_byte_lines_oe,
    .lower_byte_lines_i, .upper_byte_lines_i);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk
  // handshakes are judged from levels seen in the cycle before the edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic ar, wr, br, fin;
    fin = 1'b0;
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    while (!fin) begin
      @(negedge clk_sys);
      ar = s_axi_awready & s_axi_awvalid;
      wr = s_axi_wready & s_axi_wvalid;
      br = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clk_sys);
      if (ar) s_axi_awvalid <= 1'b0;
      if (wr) s_axi_wvalid <= 1'b0;
      if (br) s_axi_bready <= 1'b0;
      fin = br;
    end
    // one idle edge so a following call never reassigns a signal in this step
    @(posedge clk_sys);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ar, rv, fin;
    fin = 1'b0;
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    while (!fin) begin
      @(negedge clk_sys);
      ar = s_axi_arready & s_axi_arvalid;
      rv = s_axi_rvalid;
      d = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk_sys);
      if (ar) s_axi_arvalid <= 1'b0;
      if (rv) s_axi_rready <= 1'b0;
      fin = rv;
    end
    @(posedge clk_sys);
  endtask : axi_rd
  task automatic wait_done;
    int n;
    n = 0;
    v = 32'h0000_0000;
    while (v[STAT_DONE_BIT] !== 1'b1 && n < 200) begin
      axi_rd(OFS_STATUS, v, r);
      n++;
    end
    chk({30'h0, v[1:0]}, 32'h0000_0002, "status after access");
  endtask : wait_done
  task automatic op(input logic [12:0] a, input logic [4:0] f, input logic [15:0] d);
    if (f[0]) axi_wr(OFS_WDATA, {16'h0000, d}, r);
    axi_wr(OFS_CMD, {11'h000, f, 3'h0, a}, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY}, "command response");
    wait_done();
  endtask : op
  task automatic rd_mem(input logic [12:0] a, input logic [4:0] f, input logic [15:0] exp);
    op(a, f, 16'h0000);
    axi_rd(OFS_RDATA, v, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY}, "read response");
    chk(v, {16'h0000, exp}, "read data");
  endtask : rd_mem
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  // reads never overlap write strobes; single mode moves its enables in pairs
  always @(negedge clk_sys) begin
    if (rst_b && !(bank_a_output_enable_n && bank_b_output_enable_n))
      chk({30'h0, bank_a_write_enable_n, bank_b_write_enable_n}, 32'h3, "write during read");
    if (rst_b && !mode_select)
      chk({30'h0, bank_a_output_enable_n, bank_a_write_enable_n},
          {30'h0, bank_b_output_enable_n, bank_b_write_enable_n}, "paired enables");
  end
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    #1000000;
    error_cnt++;
    final_report();
  end
  initial begin
    rst_b = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    chk({31'h0, chip_enable_n}, 32'h1, "idle chip enable");
    axi_rd(OFS_CTRL, v, r);
    chk(v, CTRL_RST, "control reset value");
    axi_rd(8'h14, v, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
    axi_wr(8'h20, 32'h0000_0001, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
    $display("test reset done");
    op(13'h1123, F_W | F_A | F_LO | F_UP, 16'h1234);
    op(13'h0123, F_W | F_B | F_LO | F_UP, 16'hABCD);
    rd_mem(13'h0123, F_A | F_LO | F_UP, 16'h1234);
    rd_mem(13'h0123, F_B | F_LO | F_UP, 16'hABCD);
    op(13'h0123, F_W | F_A | F_LO, 16'h5566);
    rd_mem(13'h0123, F_A | F_LO | F_UP, 16'h1266);
    rd_mem(13'h0123, F_B | F_UP, 16'hAB00);
    op(13'h0200, F_W | F_AB, 16'h7788);
    rd_mem(13'h0200, F_A | F_LO | F_UP, 16'h7788);
    rd_mem(13'h0200, F_B | F_LO | F_UP, 16'h7788);
    $display("test dual done");
    axi_wr(OFS_CTRL, 32'h0000_0003, r);
    op(13'h0300, F_W | F_A | F_LO | F_UP, 16'h0F0F);
    rd_mem(13'h0300, F_A | F_LO | F_UP, 16'h0F0F);
    $display("test chip enable end done");
    axi_wr(OFS_CTRL, 32'h0000_0000, r);
    chk({31'h0, mode_select}, 32'h0, "mode pin single");
    op(13'h0400, F_W | F_AB, 16'h1111);
    op(13'h1400, F_W | F_AB, 16'h2222);
    rd_mem(13'h0400, F_AB, 16'h1111);
    rd_mem(13'h1400, F_AB, 16'h2222);
    axi_wr(OFS_CTRL, 32'h0000_0001, r);
    rd_mem(13'h0400, F_A | F_LO | F_UP, 16'h1111);
    rd_mem(13'h0400, F_B | F_LO | F_UP, 16'h2222);
    $display("test single done");
    axi_wr(OFS_CMD, {11'h000, F_A | F_LO | F_UP, 3'h0, 13'h0200}, r);
    axi_wr(OFS_CMD, {11'h000, F_B | F_LO, 3'h0, 13'h0123}, r);
    axi_rd(OFS_STATUS, v, r);
    chk({29'h0, v[2:0]}, 32'h0000_0005, "busy and refused");
    wait_done();
    axi_rd(OFS_RDATA, v, r);
    chk(v, 32'h0000_7788, "first command result");
    $display("test refusal done");
    final_report();
  end
endmodule : lbdc_ctrl_test
`default_nettype wire
